/* File: dv/ccu_props.sv */
/*
  checker of the counter/compare unit at its apb and output ports.
  assumes a bind into ccu_timer and a single pclk domain.
*/
`timescale 1ns/1ps
module ccu_props
  import ccu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic compare_output_a,
  input wire logic overflow_irq,
  input wire logic compare_a_irq,
  input wire logic compare_b_irq
);
  // ----------------------------------------
  // shadow of the written control state
  // ----------------------------------------
  logic wr;
  logic rd;
  logic run;
  logic [7:0] a;
  logic [7:0] ca_ff;
  logic [7:0] im_ff;
  logic [7:0] cnt_ff;
  logic [2:0] cs_ff;
  logic ok_ff;
  assign a = paddr[7:0];
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  assign rd = psel && penable && pready && !pwrite;
  assign run = cs_ff != CS_STOP;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca_ff <= CTRL_RST;
      cs_ff <= CS_STOP;
      im_ff <= CTRL_RST;
    end else if (wr) begin
      if (a == CTRL_A_ADDR) ca_ff <= pwdata[7:0];
      if (a == CTRL_B_ADDR) cs_ff <= pwdata[2:0];
      if (a == IMASK_ADDR) im_ff <= pwdata[7:0];
    end
  end
  // only trusted while the tick stayed off since the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= COUNT_RST;
      ok_ff <= 1'b0;
    end else if (wr && a == COUNT_ADDR) begin
      cnt_ff <= pwdata[7:0];
      ok_ff <= !run;
    end else if (wr && a == CTRL_B_ADDR && pwdata[2:0] != CS_STOP) begin
      ok_ff <= 1'b0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_force_a;
    wr && a == CTRL_B_ADDR && pwdata[FOCA_POS] && !ca_ff[0];
  endsequence
  property p_ready;
    s_setup |=> pready && psel && penable;
  endproperty
  property p_count_rd;
    rd && a == COUNT_ADDR && ok_ff |-> prdata == {24'h0, cnt_ff};
  endproperty
  property p_force_tgl;
    s_force_a and ca_ff[7:6] == 2'h1 |=> ##[0:2] $changed(compare_output_a);
  endproperty
  property p_force_set;
    s_force_a and ca_ff[7:6] == 2'h3 |=> ##[0:2] compare_output_a;
  endproperty
  property p_mask_a;
    !im_ff[FLGA_POS] [*2] |-> !compare_a_irq;
  endproperty
  property p_mask_b;
    !$past(im_ff[FLGB_POS]) && !im_ff[FLGB_POS] |-> !compare_b_irq;
  endproperty
  property p_mask_o;
    $rose(overflow_irq) |-> $past(im_ff[OVF_POS]);
  endproperty
  property p_ovf_src;
    $rose(overflow_irq) && $past(im_ff[OVF_POS], 2) |-> $past(run) || $past(run, 2);
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after setup");
  a_count_rd: assert property (p_count_rd)
    else $error("stopped count read differs");
  a_force_tgl: assert property (p_force_tgl)
    else $error("force did not toggle output a");
  a_force_set: assert property (p_force_set)
    else $error("force did not set output a");
  a_mask_a: assert property (p_mask_a)
    else $error("masked irq a high");
  a_mask_b: assert property (p_mask_b)
    else $error("masked irq b high");
  a_mask_o: assert property (p_mask_o)
    else $error("overflow irq rose while masked");
  a_ovf_src: assert property (p_ovf_src)
    else $error("overflow set without tick source");
endmodule

bind ccu_timer ccu_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .compare_output_a(compare_output_a),
  .overflow_irq(overflow_irq),
  .compare_a_irq(compare_a_irq),
  .compare_b_irq(compare_b_irq)
);

/* File: dv/testbench.sv */
/*
  self-checking bench of the counter/compare unit over apb.
  assumes ccu_timer and its bound checker are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  import ccu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic crystal_pin_one = 1'b0;
  logic ovf_ack = 1'b0;
  logic cmpa_ack = 1'b0;
  logic cmpb_ack = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic compare_output_a;
  logic compare_output_b;
  logic overflow_irq;
  logic compare_a_irq;
  logic compare_b_irq;
  logic [32:0] exq[$];
  logic [31:0] rnd = 32'h4ac7e48a;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  ccu_timer dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .crystal_pin_one(crystal_pin_one),
    .ovf_ack(ovf_ack),
    .cmpa_ack(cmpa_ack),
    .cmpb_ack(cmpb_ack),
    .compare_output_a(compare_output_a),
    .compare_output_b(compare_output_b),
    .overflow_irq(overflow_irq),
    .compare_a_irq(compare_a_irq),
    .compare_b_irq(compare_b_irq)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #20 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic end_sim();
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    exq.push_back({1'b0, 24'h0, v});
    xfer(1'b0, a, RD_ZERO, 4'h0);
  endtask

  // slow crystal, still between bursts
  task automatic xtal(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      crystal_pin_one <= 1'b1;
      repeat (4) @(posedge pclk);
      crystal_pin_one <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic ack(input logic [2:0] k);
    @(posedge pclk);
    {ovf_ack, cmpa_ack, cmpb_ack} <= k;
    @(posedge pclk);
    {ovf_ack, cmpa_ack, cmpb_ack} <= 3'h0;
  endtask

  task automatic outs(input logic [1:0] e);
    repeat (2) @(posedge pclk);
    chk({31'h0, compare_output_a, compare_output_b}, {31'h0, e});
  endtask

  // ----------------------------------------
  // scoreboard and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, exq.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
    exq.push_back({1'b1, RD_ZERO});
    xfer(1'b0, 8'h20, RD_ZERO, 4'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(COUNT_ADDR, rnd[7:0]);
      repeat (5) @(posedge pclk);
      rd(COUNT_ADDR, rnd[7:0]);
    end
    xfer(1'b1, COUNT_ADDR, ~rnd, 4'h0);
    rd(COUNT_ADDR, rnd[7:0]);
    // first tick after the count write must not match b
    wr(CMP_A_ADDR, 8'h12);
    wr(CMP_B_ADDR, 8'h10);
    wr(COUNT_ADDR, 8'h10);
    wr(CTRL_B_ADDR, 8'h01);
    repeat (10) @(posedge pclk);
    wr(CTRL_B_ADDR, 8'h00);
    rd(FLAG_ADDR, 8'h02);
    wr(FLAG_ADDR, 8'h00);
    rd(FLAG_ADDR, 8'h02);
    wr(FLAG_ADDR, 8'h02);
    rd(FLAG_ADDR, 8'h00);
    wr(CMP_A_ADDR, 8'h80);
    wr(CMP_B_ADDR, 8'h02);
    wr(IMASK_ADDR, 8'h01);
    wr(COUNT_ADDR, 8'hf8);
    wr(CTRL_B_ADDR, 8'h01);
    repeat (20) @(posedge pclk);
    wr(CTRL_B_ADDR, 8'h00);
    rd(FLAG_ADDR, 8'h05);
    wr(IMASK_ADDR, 8'h07);
    repeat (2) @(posedge pclk);
    chk({30'h0, overflow_irq, compare_a_irq, compare_b_irq}, 33'h5);
    ack(3'b100);
    rd(FLAG_ADDR, 8'h04);
    ack(3'b011);
    rd(FLAG_ADDR, 8'h00);
    wr(IMASK_ADDR, 8'h00);
    wr(COUNT_ADDR, 8'h00);
    wr(ASYNC_ADDR, 8'h20);
    wr(CTRL_B_ADDR, 8'h01);
    xtal(5);
    wr(CTRL_B_ADDR, 8'h00);
    rd(COUNT_ADDR, 8'h05);
    rd(FLAG_ADDR, 8'h04);
    wr(FLAG_ADDR, 8'h04);
    wr(CTRL_A_ADDR, 8'h01);
    wr(COUNT_ADDR, 8'hfe);
    wr(CTRL_B_ADDR, 8'h01);
    xtal(4);
    wr(CTRL_B_ADDR, 8'h00);
    rd(COUNT_ADDR, 8'hfc);
    wr(ASYNC_ADDR, 8'h00);
    wr(CTRL_A_ADDR, 8'h50);
    wr(CTRL_B_ADDR, 8'hc0);
    outs(2'b11);
    wr(CTRL_B_ADDR, 8'hc0);
    outs(2'b00);
    wr(CTRL_A_ADDR, 8'hf0);
    wr(CTRL_B_ADDR, 8'hc0);
    outs(2'b11);
    rd(FLAG_ADDR, 8'h00);
    wr(CTRL_A_ADDR, 8'hf3);
    outs(2'b11);
    rd(CTRL_B_ADDR, 8'h00);
    end_sim();
  end
endmodule

/* File: src/ccu_pkg.sv */
/*
  package of the 8-bit counter/compare unit: register offsets, field
  positions, reset values, waveform modes and the tick prescale table.
  assumes a 32-bit apb slave with one register per aligned word.
*/
package ccu_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] CTRL_A_ADDR = 8'h00;
  localparam logic [7:0] CTRL_B_ADDR = 8'h04;
  localparam logic [7:0] COUNT_ADDR = 8'h08;
  localparam logic [7:0] CMP_A_ADDR = 8'h0c;
  localparam logic [7:0] CMP_B_ADDR = 8'h10;
  localparam logic [7:0] FLAG_ADDR = 8'h14;
  localparam logic [7:0] ASYNC_ADDR = 8'h18;
  localparam logic [7:0] IMASK_ADDR = 8'h1c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int WGM0_POS = 0;
  localparam int WGM1_POS = 1;
  localparam int COMB_POS = 4;
  localparam int COMA_POS = 6;
  localparam int CS_POS = 0;
  localparam int WGM2_POS = 3;
  localparam int FOCB_POS = 6;
  localparam int FOCA_POS = 7;
  localparam int OVF_POS = 0;
  localparam int FLGA_POS = 1;
  localparam int FLGB_POS = 2;
  localparam int AS_POS = 5;

  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // waveform modes, coded as the 3-bit field value
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_CMP = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;

  // ticks per prescale step for clock_select_field 1..6 (others follow 1024)
  localparam logic [9:0] DIV_1 = 10'h000;
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_32 = 10'h01f;
  localparam logic [9:0] DIV_64 = 10'h03f;
  localparam logic [9:0] DIV_128 = 10'h07f;
  localparam logic [9:0] DIV_256 = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;

endpackage

/* File: src/ccu_timer.sv */
/*
  8-bit up/down counter with two output compare channels, apb registers.
  assumes one pclk domain; the crystal clock arrives as a plain input
  and is sampled through three flops, so it must run well below pclk/2.
*/
// Added by the designer: register access over APB and the address map.
// Operation
// R01 - default tick comes from the io clock
// R02 - async select picks crystal pin clock
// R03 - 8-bit counter counts up and down
// R04 - each tick clears, increments or decrements
// R05 - clock select zero stops the counter
// R06 - cpu reads/writes count anytime
// R07 - cpu count write beats clear/count
// R08 - 3-bit mode split over two registers
// R09 - overflow flag set per waveform mode
// R10 - compare count with both compare values
// R11 - match sets flag on next tick
// R12 - flag requests interrupt, cleared on service
// R13 - writing one clears flag, zero keeps
// R14 - waveform acts on match, top, bottom
// R15 - compare buffered only in pwm modes
// R16 - buffer loads at top or bottom
// R17 - cpu writes buffer or active register
// R18 - force strobe updates output, no flag
// R19 - count write blocks next tick's match
// R20 - output action change acts immediately
// R21 - output state survives mode change
// R22 - software initialises output before pin enable
// R23 - software avoids writing count equal compare
// R24 - top is 0xff or compare value a
// R25 - normal mode overflow on wrap to zero
// R26 - top and bottom indications each tick
`timescale 1ns/1ps
module ccu_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_pin_one,
  input wire logic ovf_ack,
  input wire logic cmpa_ack,
  input wire logic cmpb_ack,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic overflow_irq,
  output logic compare_a_irq,
  output logic compare_b_irq
);
  import ccu_pkg::*;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr_acc;
  logic addr_ok;
  logic [7:0] wbyte;
  assign addr_ok = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
                   (paddr[7:0] <= IMASK_ADDR);
  assign wr_acc = psel && penable && pwrite && addr_ok && pstrb[0];
  assign wbyte = pwdata[7:0];

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = wr_acc && (paddr[7:0] == a);
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctrl_a_ff;
  logic [2:0] cs_ff;
  logic wgm2_ff;
  logic async_sel_ff;
  logic [2:0] imask_ff;
  logic [2:0] mode;
  logic [1:0] act_a;
  logic [1:0] act_b;
  assign mode = {wgm2_ff, ctrl_a_ff[WGM1_POS], ctrl_a_ff[WGM0_POS]}; // [R08]
  assign act_a = ctrl_a_ff[COMA_POS +: 2]; // [R20]
  assign act_b = ctrl_a_ff[COMB_POS +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_ff <= CTRL_RST;
      cs_ff <= CS_STOP;
      wgm2_ff <= 1'b0;
      async_sel_ff <= 1'b0;
      imask_ff <= 3'h0;
    end else begin
      if (wr_to(CTRL_A_ADDR)) begin
        ctrl_a_ff <= wbyte;
      end
      if (wr_to(CTRL_B_ADDR)) begin
        cs_ff <= wbyte[CS_POS +: 3];
        wgm2_ff <= wbyte[WGM2_POS];
      end
      if (wr_to(ASYNC_ADDR)) begin
        async_sel_ff <= wbyte[AS_POS]; // [R02]
      end
      if (wr_to(IMASK_ADDR)) begin
        imask_ff <= wbyte[2:0];
      end
    end
  end

  logic pwm_mode;
  logic top_is_cmp;
  logic dual_slope;
  assign pwm_mode = (mode != WM_NORMAL) && (mode != WM_CTC) && (mode[1:0] != 2'h2); // [R15]
  assign top_is_cmp = (mode == WM_CTC) || (mode == WM_PC_CMP) || (mode == WM_FAST_CMP);
  assign dual_slope = (mode[1:0] == 2'h1);

  // ----------------------------------------
  // tick source
  // ----------------------------------------
  // crystal clock treated as an asynchronous pin: three flops, edge once the last two stages agree
  logic [2:0] xtal_sync_ff;
  logic xtal_seen_ff;
  logic xtal_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_sync_ff <= 3'h0;
      xtal_seen_ff <= 1'b0;
    end else begin
      xtal_sync_ff <= {xtal_sync_ff[1:0], crystal_pin_one};
      if (xtal_sync_ff[2] == xtal_sync_ff[1]) begin
        xtal_seen_ff <= xtal_sync_ff[2];
      end
    end
  end
  assign xtal_rise = (xtal_sync_ff[2] == xtal_sync_ff[1]) && xtal_sync_ff[2] && !xtal_seen_ff;

  logic [9:0] pre_ff;
  logic src_edge;
  logic [9:0] div_lim;
  logic tick;
  assign src_edge = async_sel_ff ? xtal_rise : 1'b1; // [R01] [R02]
  always_comb begin
    case (cs_ff)
      3'h1: div_lim = DIV_1;
      3'h2: div_lim = DIV_8;
      3'h3: div_lim = DIV_32;
      3'h4: div_lim = DIV_64;
      3'h5: div_lim = DIV_128;
      3'h6: div_lim = DIV_256;
      default: div_lim = DIV_1024;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 10'h000;
    end else if (cs_ff == CS_STOP) begin
      pre_ff <= 10'h000;
    end else if (src_edge) begin
      pre_ff <= (pre_ff >= div_lim) ? 10'h000 : pre_ff + 10'h001;
    end
  end
  assign tick = (cs_ff != CS_STOP) && src_edge && (pre_ff >= div_lim); // [R05]

  // ----------------------------------------
  // counter unit
  // ----------------------------------------
  logic [7:0] count_value_ff;
  logic [7:0] nxt_count;
  logic down_ff;
  logic nxt_down;
  logic [7:0] compare_value_a_ff;
  logic [7:0] compare_value_b_ff;
  logic [7:0] buf_a_ff;
  logic [7:0] buf_b_ff;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic count_wr;
  assign top_val = top_is_cmp ? compare_value_a_ff : MAX_VAL; // [R24]
  assign at_top = (count_value_ff == top_val); // [R26]
  assign at_bottom = (count_value_ff == BOTTOM_VAL);
  assign count_wr = wr_to(COUNT_ADDR);

  always_comb begin
    nxt_count = count_value_ff;
    nxt_down = down_ff;
    if (tick) begin
      if (dual_slope) begin
        if (at_top && !down_ff) begin
          nxt_down = 1'b1; // [R03]
        end else if (at_bottom && down_ff) begin
          nxt_down = 1'b0;
        end
        if (nxt_down) begin
          nxt_count = count_value_ff - 8'h01; // [R04]
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
      end else begin
        nxt_down = 1'b0;
        if (at_top && mode != WM_NORMAL) begin
          nxt_count = BOTTOM_VAL;
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_ff <= COUNT_RST;
      down_ff <= 1'b0;
    end else begin
      down_ff <= nxt_down;
      if (count_wr) begin
        count_value_ff <= wbyte; // [R06] [R07]
      end else begin
        count_value_ff <= nxt_count;
      end
    end
  end

  // ----------------------------------------
  // compare registers and buffering
  // ----------------------------------------
  logic load_pt;
  assign load_pt = tick && (dual_slope ? at_top : at_bottom); // [R16]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_a_ff <= COUNT_RST;
      buf_b_ff <= COUNT_RST;
      compare_value_a_ff <= COUNT_RST;
      compare_value_b_ff <= COUNT_RST;
    end else begin
      if (wr_to(CMP_A_ADDR)) begin
        buf_a_ff <= wbyte; // [R17]
      end
      if (wr_to(CMP_B_ADDR)) begin
        buf_b_ff <= wbyte;
      end
      if (!pwm_mode) begin
        // buffer follows active so a later switch to pwm starts coherent
        if (wr_to(CMP_A_ADDR)) begin
          compare_value_a_ff <= wbyte; // [R17]
        end
        if (wr_to(CMP_B_ADDR)) begin
          compare_value_b_ff <= wbyte;
        end
      end else if (load_pt) begin
        compare_value_a_ff <= buf_a_ff; // [R15] [R16]
        compare_value_b_ff <= buf_b_ff;
      end
    end
  end

  // ----------------------------------------
  // match, blocking and flags
  // ----------------------------------------
  logic block_ff;
  logic match_a;
  logic match_b;
  logic cmp_ev_a;
  logic cmp_ev_b;
  logic ovf_ev;
  assign match_a = (count_value_ff == compare_value_a_ff); // [R10]
  assign match_b = (count_value_ff == compare_value_b_ff);
  // blocking lasts until the next tick, however long the counter is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_ff <= 1'b0;
    end else if (count_wr) begin
      block_ff <= 1'b1; // [R19]
    end else if (tick) begin
      block_ff <= 1'b0;
    end
  end
  assign cmp_ev_a = tick && match_a && !block_ff && !count_wr; // [R11] [R19]
  assign cmp_ev_b = tick && match_b && !block_ff && !count_wr;
  assign ovf_ev = tick && !count_wr &&
                  (dual_slope ? (at_bottom && down_ff) :
                   (mode == WM_NORMAL || mode == WM_CTC) ? (count_value_ff == MAX_VAL) :
                   at_top); // [R09] [R25]

  logic [2:0] flag_ff;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set = {cmp_ev_b, cmp_ev_a, ovf_ev};
  assign flag_clr = ({3{wr_to(FLAG_ADDR)}} & wbyte[2:0]) | // [R13]
                    {cmpb_ack, cmpa_ack, ovf_ack}; // [R12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 3'h0;
    end else begin
      flag_ff <= flag_set | (flag_ff & ~flag_clr); // set wins over clear
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
    end else begin
      overflow_irq <= flag_ff[OVF_POS] && imask_ff[OVF_POS] && !ovf_ack; // [R09]
      compare_a_irq <= flag_ff[FLGA_POS] && imask_ff[FLGA_POS] && !cmpa_ack; // [R12]
      compare_b_irq <= flag_ff[FLGB_POS] && imask_ff[FLGB_POS] && !cmpb_ack;
    end
  end

  // ----------------------------------------
  // waveform generator
  // ----------------------------------------
  logic force_a;
  logic force_b;
  assign force_a = wr_to(CTRL_B_ADDR) && wbyte[FOCA_POS] && !pwm_mode; // [R18]
  assign force_b = wr_to(CTRL_B_ADDR) && wbyte[FOCB_POS] && !pwm_mode;

  function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                     input logic hit, input logic frc,
                                     input logic pwm, input logic dual,
                                     input logic dn, input logic bot);
    logic r;
    r = cur;
    if (pwm) begin
      // only 2 and 3 act in pwm; 3 is the inverted form
      if (act[1]) begin
        if (hit) begin
          r = dual ? (dn ^ act[0]) : act[0];
        end else if (bot && !dual) begin
          r = !act[0];
        end
      end
    end else if (hit || frc) begin
      case (act)
        2'h1: r = !cur;
        2'h2: r = 1'b0;
        2'h3: r = 1'b1;
        default: r = cur;
      endcase
    end
    wave_next = r;
  endfunction

  logic nxt_oc_a;
  logic nxt_oc_b;
  assign nxt_oc_a = wave_next(compare_output_a, act_a, cmp_ev_a, force_a, pwm_mode,
                              dual_slope, nxt_down, tick && at_bottom); // [R14] [R20]
  assign nxt_oc_b = wave_next(compare_output_b, act_b, cmp_ev_b, force_b, pwm_mode,
                              dual_slope, nxt_down, tick && at_bottom);
  // output state has no mode-dependent reset path, so it survives mode changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
    end else begin
      compare_output_a <= nxt_oc_a; // [R21] [R22]
      compare_output_b <= nxt_oc_b;
    end
  end

  // ----------------------------------------
  // apb read and response
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr[7:0])
      CTRL_A_ADDR: rd_byte = ctrl_a_ff;
      CTRL_B_ADDR: rd_byte = {4'h0, wgm2_ff, cs_ff}; // force bits read zero
      COUNT_ADDR: rd_byte = count_value_ff; // [R06]
      CMP_A_ADDR: rd_byte = pwm_mode ? buf_a_ff : compare_value_a_ff; // [R17]
      CMP_B_ADDR: rd_byte = pwm_mode ? buf_b_ff : compare_value_b_ff;
      FLAG_ADDR: rd_byte = {5'h00, flag_ff};
      ASYNC_ADDR: rd_byte = {2'h0, async_sel_ff, 5'h00};
      IMASK_ADDR: rd_byte = {5'h00, imask_ff};
      default: rd_byte = 8'h00;
    endcase
  end

  // zero-wait slave: setup phase registers ready, access completes next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= addr_ok ? {24'h000000, rd_byte} : RD_ZERO;
      end
    end
  end
endmodule
